//--- hw/bintr_pkg.sv
// Purpose: shared constants and types of the four-source bus interrupter
// Assumes: 8-bit registers, three address lines, seven request levels
// Notes: control and vector field layout, reset values, fsm codes
package bintr_pkg;
  localparam int NUM_SRC = 4;
  localparam int LVL_W = 3;
  localparam int NUM_LVL = 7;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // control register field positions
  localparam int LVL_LSB = 0;
  localparam int BIT_AUTOCLR = 3;
  localparam int BIT_GATE = 4;
  localparam int BIT_EXT = 5;
  localparam int BIT_FAC = 6;
  localparam int BIT_FLAG = 7;
  // address bit that selects the vector bank
  localparam int ADDR_VEC_BIT = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h0F;
  localparam logic [2:0] LVL_OFF = 3'h0;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ACCESS = 5'h02,
    ST_VECTOR = 5'h04,
    ST_EXT    = 5'h08,
    ST_PASS   = 5'h10
  } bintr_state_type;
endpackage : bintr_pkg

//--- hw/bintr_sync.sv
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to i_clk_sys
// Notes: first stage feeds only the second stage
module bintr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  // hold both stages while the clock enable is low
  always_comb begin
    next_stage1 = i_ce ? i_async : stage1;
    next_sync = i_ce ? stage1 : o_sync;
  end

  // register both stages
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule : bintr_sync

//--- hw/bintr_top.sv
// Purpose: bus interrupter for four local sources with vectored acknowledge
// Assumes: all bus pins asynchronous; open-collector pins driven via enables
// Notes: cs and iack low together perform the on-board reset
//
// Contract
// [RULE_01] serve four sources, active-low request inputs
// [RULE_02] raise request on the source's single level
// [RULE_03] acknowledge answers vector or passes daisy chain
// [RULE_04] drop request once its acknowledge serviced it
// [RULE_05] four vector registers supply acknowledge byte
// [RULE_06] four control registers hold level and gate
// [RULE_07] control register holds a software flag bit
// [RULE_08] all eight registers read and write
// [RULE_09] 8-bit data bus released when idle
// [RULE_10] level field zero disables, else line number
// [RULE_11] gate bit, auto-cleared when auto-clear bit set
// [RULE_12] external bit suppresses vector and acknowledge
// [RULE_13] reset clears control, vectors become 0F
// [RULE_14] request held while input active until acknowledged
module bintr_top #(
  parameter int N_SRC = bintr_pkg::NUM_SRC
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [3:0] i_local_irq_inputs_n,
  input wire logic i_cs_n,
  input wire logic i_iack_n,
  input wire logic i_iackin_n,
  input wire logic i_rw,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_dtack_oe,
  output logic [7:1] o_irq_oe,
  output logic o_iackout_n,
  output logic o_intae_n,
  output logic [1:0] o_intal
);
  generate
    if (N_SRC != 4) begin : g_bad_src
      $error("bintr_top supports exactly four sources");
    end
  endgenerate

  // synchronised pins
  logic [18:0] pins_sync;
  logic [3:0] local_act;
  logic cs, iack, iackin, rd;
  logic [2:0] addr;
  logic [7:0] din;

  bintr_sync #(
    .WIDTH(19),
    .RST_VAL(19'h0007F)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_async({i_data, i_addr, i_rw, i_iackin_n, i_iack_n, i_cs_n,
              i_local_irq_inputs_n}),
    .o_sync(pins_sync)
  );

  // active-high views of the synchronised pins
  assign local_act = ~pins_sync[3:0]; // RULE_01
  assign cs = ~pins_sync[4];
  assign iack = ~pins_sync[5];
  assign iackin = ~pins_sync[6];
  assign rd = pins_sync[7];
  assign addr = pins_sync[10:8];
  assign din = pins_sync[18:11];

  logic [7:0] ctrl [4], vec [4], next_ctrl [4], next_vec [4];
  logic [3:0] done, next_done, pend;
  logic [7:1] next_irq;
  bintr_pkg::bintr_state_type st, next_st;
  logic [7:0] next_data;
  logic [1:0] next_intal, hit_idx;
  logic next_data_oe, soft_rst, hit, go_vec, go_ext, serve;

  // register select: low bank control, high bank vector
  function automatic logic [7:0] read_reg(input logic [2:0] a,
      input logic [7:0] c [4], input logic [7:0] v [4]);
    return a[bintr_pkg::ADDR_VEC_BIT] ? v[a[1:0]] : c[a[1:0]];
  endfunction : read_reg

  function automatic logic [2:0] lvl_of(input logic [7:0] c);
    return c[bintr_pkg::LVL_LSB +: bintr_pkg::LVL_W];
  endfunction : lvl_of

  // pending request per source, withheld once serviced
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pend[i] = local_act[i] && ctrl[i][bintr_pkg::BIT_GATE] // RULE_11
        && (lvl_of(ctrl[i]) != bintr_pkg::LVL_OFF) // RULE_10
        && !done[i]; // RULE_04 RULE_14
    end
  end

  // lowest-numbered pending source matching the acknowledged level
  always_comb begin
    hit = 1'b0;
    hit_idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (pend[i] && lvl_of(ctrl[i]) == addr) begin
        hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
  end

  assign soft_rst = cs && iack;
  assign serve = (st == bintr_pkg::ST_IDLE) && !soft_rst && iack
    && iackin && hit;
  assign go_ext = serve && ctrl[hit_idx][bintr_pkg::BIT_EXT]; // RULE_12
  assign go_vec = serve && !ctrl[hit_idx][bintr_pkg::BIT_EXT];

  // register file next values: writes, auto clears, on-board reset
  always_comb begin
    next_ctrl = ctrl;
    next_vec = vec;
    if (soft_rst) begin
      for (int i = 0; i < 4; i++) begin
        next_ctrl[i] = bintr_pkg::CTRL_RST; // RULE_13
        next_vec[i] = bintr_pkg::VEC_RST; // RULE_13
      end
    end else if (st == bintr_pkg::ST_IDLE && cs && !rd) begin
      if (addr[bintr_pkg::ADDR_VEC_BIT]) begin
        next_vec[addr[1:0]] = din; // RULE_05 RULE_08
      end else begin
        next_ctrl[addr[1:0]] = din; // RULE_06 RULE_07 RULE_08
      end
    end else if (serve) begin
      if (ctrl[hit_idx][bintr_pkg::BIT_AUTOCLR]) begin
        next_ctrl[hit_idx][bintr_pkg::BIT_GATE] = 1'b0; // RULE_11
      end
      if (ctrl[hit_idx][bintr_pkg::BIT_FAC]) begin
        next_ctrl[hit_idx][bintr_pkg::BIT_FLAG] = 1'b0; // RULE_07
      end
    end
  end

  // registers hold their value while the clock enable is low
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < 4; i++) begin
        ctrl[i] <= bintr_pkg::CTRL_RST; // RULE_13
        vec[i] <= bintr_pkg::VEC_RST;
      end
    end else if (i_ce) begin
      ctrl <= next_ctrl;
      vec <= next_vec;
    end
  end

  // serviced marks and request lines
  always_comb begin
    next_irq = 7'h00;
    for (int i = 0; i < 4; i++) begin
      next_done[i] = (done[i] && local_act[i]) // RULE_04
        || (serve && hit_idx == 2'(i));
      if (soft_rst) begin
        next_done[i] = 1'b0;
      end
      for (int l = 1; l <= bintr_pkg::NUM_LVL; l++) begin
        if (pend[i] && lvl_of(ctrl[i]) == 3'(l)) begin
          next_irq[l] = 1'b1; // RULE_02 RULE_14
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      done <= 4'h0;
      o_irq_oe <= 7'h00;
    end else if (i_ce) begin
      done <= next_done;
      o_irq_oe <= next_irq;
    end
  end

  // bus cycle sequencer
  always_comb begin
    next_st = st;
    next_data = o_data;
    next_data_oe = o_data_oe;
    next_intal = o_intal;
    unique case (st)
      bintr_pkg::ST_IDLE: begin
        if (soft_rst) begin
          next_st = bintr_pkg::ST_IDLE;
        end else if (cs) begin
          next_st = bintr_pkg::ST_ACCESS;
          next_data_oe = rd; // RULE_09
          next_data = read_reg(addr, ctrl, vec); // RULE_08
        end else if (go_vec) begin
          next_st = bintr_pkg::ST_VECTOR; // RULE_03
          next_data_oe = 1'b1;
          next_data = vec[hit_idx]; // RULE_05
        end else if (go_ext) begin
          next_st = bintr_pkg::ST_EXT; // RULE_12
          next_intal = hit_idx;
        end else if (iack && iackin) begin
          next_st = bintr_pkg::ST_PASS; // RULE_03
        end
      end
      bintr_pkg::ST_ACCESS: begin
        if (!cs) begin
          next_st = bintr_pkg::ST_IDLE;
          next_data_oe = 1'b0; // RULE_09
        end
      end
      bintr_pkg::ST_VECTOR, bintr_pkg::ST_EXT, bintr_pkg::ST_PASS: begin
        if (!iack) begin
          next_st = bintr_pkg::ST_IDLE;
          next_data_oe = 1'b0; // RULE_09
        end
      end
      default: begin
        next_st = bintr_pkg::ST_IDLE;
        next_data_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= bintr_pkg::ST_IDLE;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
      o_intal <= 2'h0;
    end else if (i_ce) begin
      st <= next_st;
      o_data <= next_data;
      o_data_oe <= next_data_oe;
      o_intal <= next_intal;
    end
  end

  // handshake outputs from the state register
  assign o_dtack_oe = (st == bintr_pkg::ST_ACCESS)
    || (st == bintr_pkg::ST_VECTOR); // RULE_12
  assign o_iackout_n = (st != bintr_pkg::ST_PASS); // RULE_03
  assign o_intae_n = (st != bintr_pkg::ST_EXT);

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn || !i_ce);
  sequence ack_taken_s;
    (st == bintr_pkg::ST_IDLE) && go_vec;
  endsequence
  sequence vector_out_s;
    o_dtack_oe && o_data_oe && (st == bintr_pkg::ST_VECTOR);
  endsequence
  src0_level_a: assert property ( // RULE_02
    pend[0]
    |=> o_irq_oe[$past(ctrl[0][bintr_pkg::LVL_LSB +: bintr_pkg::LVL_W])])
    else $error("source 0 request missing on its level");
  vector_answer_a: assert property ( // RULE_03
    ack_taken_s |=> vector_out_s and (o_data == vec[$past(hit_idx)]))
    else $error("vector answer wrong");
  chain_pass_a: assert property ( // RULE_03
    (st == bintr_pkg::ST_IDLE && iack && iackin && !cs && !hit)
    |=> !o_iackout_n && !o_dtack_oe)
    else $error("daisy chain not passed on");
  withdraw_req_a: assert property ( // RULE_04
    serve |=> !pend[$past(hit_idx)]
      ##1 (!o_irq_oe[$past(addr, 2)] || $past(pend) != 4'h0))
    else $error("serviced request not withdrawn");
  level_off_a: assert property ( // RULE_10
    (lvl_of(ctrl[1]) == bintr_pkg::LVL_OFF) |-> !pend[1])
    else $error("disabled level still pending");
  gate_autoclr_a: assert property ( // RULE_11
    (serve && ctrl[hit_idx][bintr_pkg::BIT_AUTOCLR])
    |=> !ctrl[$past(hit_idx)][bintr_pkg::BIT_GATE])
    else $error("gate not auto-cleared");
  flag_autoclr_a: assert property ( // RULE_07
    (serve && ctrl[hit_idx][bintr_pkg::BIT_FAC])
    |=> !ctrl[$past(hit_idx)][bintr_pkg::BIT_FLAG])
    else $error("flag not auto-cleared");
  ext_quiet_a: assert property ( // RULE_12
    (st == bintr_pkg::ST_EXT) |-> !o_dtack_oe && !o_data_oe && !o_intae_n)
    else $error("external response drove the bus");
  write_store_a: assert property ( // RULE_08
    (st == bintr_pkg::ST_IDLE && cs && !iack && !rd)
    |=> read_reg($past(addr), ctrl, vec) == $past(din))
    else $error("register write lost");
  bus_release_a: assert property ( // RULE_09
    o_data_oe |-> (st == bintr_pkg::ST_ACCESS
      || st == bintr_pkg::ST_VECTOR))
    else $error("data bus driven outside a cycle");
  soft_reset_a: assert property ( // RULE_13
    soft_rst |=> vec[2] == bintr_pkg::VEC_RST && ctrl[2] == 8'h00)
    else $error("on-board reset values wrong");
endmodule : bintr_top

//--- test/bintr_handler.sv
// Purpose: bus master and acknowledge handler facing the interrupter
// Assumes: set-up held two edges before a strobe falls
// Notes: released write data shows the inverse of the last byte
module bintr_handler (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe,
  input wire logic i_dtack,
  input wire logic i_iackout_n,
  input wire logic i_intae_n,
  input wire logic [1:0] i_intal,
  output logic o_cs_n,
  output logic o_iack_n,
  output logic o_iackin_n,
  output logic o_rw,
  output logic [2:0] o_addr,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    o_cs_n = 1'b1;
    o_iack_n = 1'b1;
    o_iackin_n = 1'b1;
    o_rw = 1'b1;
    o_addr = 3'h0;
    o_data = 8'h00;
  end

  // one register or acknowledge cycle; how = dtack,data,intae,pass
  task automatic cyc(input logic ack, input logic rw,
      input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [3:0] how);
    int n;
    n = 0;
    how = 4'h0;
    q = 8'h00;
    o_rw <= rw;
    o_addr <= a;
    o_data <= d;
    repeat (2) @(posedge i_clk_sys);
    o_cs_n <= ack;
    o_iack_n <= !ack;
    o_iackin_n <= !ack;
    while (how == 4'h0 && n < 30) begin
      @(posedge i_clk_sys);
      n++;
      how = {i_dtack, i_data_oe, !i_intae_n, !i_iackout_n};
      q = i_intae_n ? i_data : {6'h00, i_intal};
    end
    o_cs_n <= 1'b1;
    o_iack_n <= 1'b1;
    o_iackin_n <= 1'b1;
    o_data <= ~d;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while ((i_dtack | i_data_oe | !i_intae_n | !i_iackout_n) && n < 30);
    @(posedge i_clk_sys);
  endtask : cyc

  // select and acknowledge low together force the on-board reset
  task automatic soft_reset();
    o_cs_n <= 1'b0;
    o_iack_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    o_iack_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask : soft_reset
endmodule : bintr_handler

//--- test/bintr_top_test.sv
// Purpose: self-checking bench of the four-source interrupter
// Assumes: clock enable dropped once to freeze a standing request
// Notes: expectations follow the control field layout
`define CHK(nm, exp, got) \
  begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, (exp), (got)); end end
module bintr_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys;
  logic rstn;
  logic ce;
  logic [3:0] irq_n;
  logic cs_n, iack_n, iackin_n, rw, data_oe, dtack_oe, iackout_n, intae_n;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [7:1] irq_oe;
  logic [1:0] intal;
  logic [3:0] how;
  int errors = 0;
  int checks_done = 0;

  bintr_top DUT (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_ce(ce),
    .i_local_irq_inputs_n(irq_n), .i_cs_n(cs_n), .i_iack_n(iack_n),
    .i_iackin_n(iackin_n), .i_rw(rw), .i_addr(addr), .i_data(wdata),
    .o_data(rdata), .o_data_oe(data_oe), .o_dtack_oe(dtack_oe),
    .o_irq_oe(irq_oe), .o_iackout_n(iackout_n), .o_intae_n(intae_n),
    .o_intal(intal));

  bintr_handler HM (.i_clk_sys(clk_sys), .i_data(rdata),
    .i_data_oe(data_oe), .i_dtack(dtack_oe), .i_iackout_n(iackout_n),
    .i_intae_n(intae_n), .i_intal(intal), .o_cs_n(cs_n),
    .o_iack_n(iack_n), .o_iackin_n(iackin_n), .o_rw(rw),
    .o_addr(addr), .o_data(wdata));

  // verdict and end of run
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // register write, expecting a plain acknowledge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    HM.cyc(1'b0, 1'b0, a, d, q, how);
    `CHK("write ack", 4'h8, how)
  endtask : wr

  // register read compared against expected byte
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    HM.cyc(1'b0, 1'b1, a, 8'h00, q, how);
    `CHK("read ack", 4'hC, how)
    `CHK("read data", e, q)
  endtask : rd

  // acknowledge on level l
  task automatic ack(input logic [2:0] l, input logic [3:0] eh,
      input logic [7:0] eq);
    HM.cyc(1'b1, 1'b1, l, 8'h00, q, how);
    `CHK("ack kind", eh, how)
    if (eh != 4'h1) `CHK("ack byte", eq, q)
  endtask : ack

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    logic [2:0] l;
    irq_n <= 4'hF;
    ce <= 1'b1;
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int s = 0; s < 8; s++) begin
      rd(3'(s), s < 4 ? 8'h00 : 8'h0F);
      wr(3'(s), 8'hC0 | 8'(s));
      rd(3'(s), 8'hC0 | 8'(s));
    end
    for (int s = 0; s < 3; s++) begin
      l = 3'(2 * s + 1);
      wr(3'(s + 4), 8'h40 + 8'(s));
      wr(3'(s), 8'hD8 | 8'(l));
      irq_n[s] <= 1'b0;
      repeat (5) @(posedge clk_sys);
      `CHK("request line", 7'h01 << (l - 1), irq_oe)
      ack(l, 4'hC, 8'h40 + 8'(s));
      `CHK("withdrawn", 7'h00, irq_oe)
      rd(3'(s), 8'h48 | 8'(l));
      irq_n[s] <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    ack(3'h2, 4'h1, 8'h00);
    wr(3'h3, 8'h37);
    irq_n[3] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ack(3'h7, 4'h2, 8'h03);
    irq_n[3] <= 1'b1;
    wr(3'h0, 8'h01);
    irq_n[0] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK("gate off", 7'h00, irq_oe)
    wr(3'h0, 8'h10);
    repeat (5) @(posedge clk_sys);
    `CHK("level zero", 7'h00, irq_oe)
    `CHK("bus released", 1'b0, data_oe)
    wr(3'h0, 8'h16);
    repeat (5) @(posedge clk_sys);
    `CHK("level six", 7'h20, irq_oe)
    ce <= 1'b0;
    irq_n[0] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("frozen", 7'h20, irq_oe)
    ce <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("released", 7'h00, irq_oe)
    HM.soft_reset();
    rd(3'h0, 8'h00);
    rd(3'h7, 8'h0F);
    report_and_stop();
  end
endmodule : bintr_top_test
